/* igp_pkg.sv */
// Purpose: shared constants for the inverter gate drive controller
// Assumes: 250 MHz core clock
// Notes: times kept in their own unit, counts derived from them
package igp_pkg;
	localparam int CLK_MHZ = 250;
	// shortest pulse the module honours, in microseconds
	localparam int MIN_PULSE_US = 1;
	localparam int MIN_PULSE_CYC = MIN_PULSE_US * CLK_MHZ;
	// default dead time, in nanoseconds, covering switching delays
	localparam int DEAD_NS = 2000;
	localparam int DEAD_CYC = (DEAD_NS * CLK_MHZ + 999) / 1000;
	// fault clear time with built-in default, in microseconds
	localparam int CLEAR_US = 2000;
	localparam int CLEAR_CYC = CLEAR_US * CLK_MHZ;
	localparam int PHASES = 3;
	// per-phase command encoding
	typedef enum logic [1:0] {IGP_OFF, IGP_UP, IGP_LOW} igp_cmd_t;
endpackage

/* igp_phase_if.sv */
`timescale 1ns/10ps
// Purpose: carrier between the top and one phase sequencer
// Assumes: single clock domain
// Notes: plain signals, no clocking block
interface igp_phase_if;
	igp_pkg::igp_cmd_t cmd;
	logic kill;
	logic up_drv;
	logic low_drv;
	modport top (output cmd, output kill, input up_drv, input low_drv);
	modport seq (input cmd, input kill, output up_drv, output low_drv);
endinterface

/* igp_phase_seq.sv */
`timescale 1ns/10ps
// Purpose: one phase sequencer with dead time and minimum pulse width
// Assumes: kill forces both drives low at once
// Notes: never both drives high
module igp_phase_seq #(
	parameter int DEAD_CYC = igp_pkg::DEAD_CYC,
	parameter int MIN_CYC = igp_pkg::MIN_PULSE_CYC
)(
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// phase carrier
	igp_phase_if.seq ph
);
	localparam int CW = $clog2(DEAD_CYC + MIN_CYC + 2);
	typedef enum {S_IDLE, S_DEAD, S_UP, S_LOW} igp_seq_t;
	igp_seq_t state_ff;
	logic [CW-1:0] cnt_ff;
	// refuse counts the sequencer cannot serve
	if (DEAD_CYC < 1 || MIN_CYC < 1)
	begin : g_bad_counts
		$error("dead time and pulse width must be at least one cycle");
	end
	// counter reload on every state change
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			state_ff <= S_IDLE;
			cnt_ff <= '0;
		end
		else if (ph.kill)
		begin
			state_ff <= S_IDLE;
			cnt_ff <= CW'(MIN_CYC);
		end
		else if (cnt_ff != '0)
			cnt_ff <= cnt_ff - 1'b1;
		else
		begin
			case (state_ff)
				S_IDLE:
				begin
					if (ph.cmd != igp_pkg::IGP_OFF)
					begin
						state_ff <= S_DEAD;
						cnt_ff <= CW'(DEAD_CYC - 1);
					end
				end
				S_DEAD:
				begin
					if (ph.cmd == igp_pkg::IGP_UP)
						state_ff <= S_UP;
					else if (ph.cmd == igp_pkg::IGP_LOW)
						state_ff <= S_LOW;
					else
						state_ff <= S_IDLE;
					cnt_ff <= CW'(MIN_CYC - 1);
				end
				S_UP, S_LOW:
				begin
					// any change passes through a dead period
					if ((state_ff == S_UP && ph.cmd != igp_pkg::IGP_UP) ||
						(state_ff == S_LOW && ph.cmd != igp_pkg::IGP_LOW))
					begin
						state_ff <= S_DEAD;
						cnt_ff <= CW'(DEAD_CYC - 1);
					end
				end
				default:
					state_ff <= S_IDLE;
			endcase
		end
	end
	// drives decoded from state, so they cannot overlap
	assign ph.up_drv = (state_ff == S_UP) && !ph.kill;
	assign ph.low_drv = (state_ff == S_LOW) && !ph.kill;
endmodule // igp_phase_seq

/* igp_gate_ctrl.sv */
`timescale 1ns/10ps
// Purpose: motor controller side driving a three-phase power module
// Assumes: module fault pin is open drain, pulled up, sampled here
// Notes: gate inputs go low on the edge after any sampled fault
//   the clear timer restarts while the pin stays low
//   upper requests wait until a lower request starts a run
//   a user stop may cut a gate pulse short of the minimum
//   kill acts on the sequencers and on the pin flops alike
//   reset release reaches the core only after two flops
//   status outputs decode straight from flops
module igp_gate_ctrl #(
	parameter int CLEAR_CYC = igp_pkg::CLEAR_CYC,
	parameter int DEAD_CYC = igp_pkg::DEAD_CYC,
	parameter int MIN_CYC = igp_pkg::MIN_PULSE_CYC
)(
	// clock and reset
	input wire logic core_clk_in,
	input wire logic reset_n_in,
	// user commands, one enable and requests one per phase
	input wire logic enable_in,
	input wire logic [2:0] upper_req_in,
	input wire logic [2:0] lower_req_in,
	// fault pin of the module, open drain
	input wire logic fault_n_pin_in,
	// gate inputs to the module
	output logic upper_gate_input_phase_u_out,
	output logic upper_gate_input_phase_v_out,
	output logic upper_gate_input_phase_w_out,
	output logic lower_gate_input_phase_u_out,
	output logic lower_gate_input_phase_v_out,
	output logic lower_gate_input_phase_w_out,
	// shutdown pin and status
	output logic driver_shutdown_input_out,
	output logic fault_seen_out,
	output logic ready_out
);
	localparam int CCW = $clog2(CLEAR_CYC + 1);
	typedef enum {ST_WAIT, ST_RUN, ST_HOLD} igp_top_t;
	// reset copy and synchronised fault pin
	logic [1:0] rst_sync_ff;
	logic rst_n;
	logic [1:0] fault_sync_ff;
	logic fault_n;
	// protection state and clear timer
	igp_top_t state_ff;
	logic [CCW-1:0] clear_ff;
	// per-phase drives before and after the pin flops
	logic kill;
	logic [2:0] up_drv;
	logic [2:0] low_drv;
	logic [2:0] up_q_ff;
	logic [2:0] low_q_ff;
	// refuse settings the counters cannot serve
	if (CLEAR_CYC < 1)
	begin : g_bad_clear
		$error("clear interval must be at least one cycle");
	end
	if (DEAD_CYC < 1 || MIN_CYC < 1)
	begin : g_bad_seq
		$error("dead time and pulse width must be at least one cycle");
	end
	// the pin set is fixed at three phase pairs
	if (igp_pkg::PHASES != 3)
	begin : g_bad_phases
		$error("phase count must match the three pin pairs");
	end
	// reset release through two flops
	// assertion stays asynchronous, only the release is clocked
	always_ff @(posedge core_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			rst_sync_ff <= 2'h0;
		else
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
	end
	assign rst_n = rst_sync_ff[1];
	// fault pin is asynchronous, two flops before use
	// idles high so no false fault follows reset
	always_ff @(posedge core_clk_in or negedge rst_n)
	begin
		if (!rst_n)
			fault_sync_ff <= 2'h3;
		else
			fault_sync_ff <= {fault_sync_ff[0], fault_n_pin_in};
	end
	assign fault_n = fault_sync_ff[1];
	// fault kills, then wait the clear interval before restart
	always_ff @(posedge core_clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_ff <= ST_WAIT;
			clear_ff <= '0;
		end
		// timer reloads every cycle the pin stays low
		else if (!fault_n)
		begin
			state_ff <= ST_HOLD;
			clear_ff <= CCW'(CLEAR_CYC);
		end
		else
		begin
			case (state_ff)
				ST_HOLD:
				begin
					// drives stay off until the timer runs out
					if (clear_ff != '0)
						clear_ff <= clear_ff - 1'b1;
					else
						state_ff <= ST_WAIT;
				end
				ST_WAIT:
				begin
					// module idles until a lower input arrives
					if (enable_in && (|lower_req_in))
						state_ff <= ST_RUN;
				end
				ST_RUN:
				begin
					// a user stop drops back to waiting for a lower
					if (!enable_in)
						state_ff <= ST_WAIT;
				end
				default:
					state_ff <= ST_WAIT;
			endcase
		end
	end
	// combinational kill avoids a cycle of drive after a fault
	// a user stop kills as well, so a stop may cut a pulse short
	assign kill = !fault_n ||
		state_ff == ST_HOLD ||
		!enable_in;
	// one sequencer per phase, each with its own carrier
	genvar gi;
	generate
		for (gi = 0; gi < igp_pkg::PHASES; gi++)
		begin : g_ph
			igp_phase_if pif();
			// both requests at once never reach the module
			always_comb
			begin
				if (upper_req_in[gi] && !lower_req_in[gi])
					pif.cmd = igp_pkg::IGP_UP;
				else if (lower_req_in[gi] && !upper_req_in[gi])
					pif.cmd = igp_pkg::IGP_LOW;
				else
					pif.cmd = igp_pkg::IGP_OFF;
				// only lower drive allowed while waiting to start
				if (state_ff == ST_WAIT && pif.cmd == igp_pkg::IGP_UP)
					pif.cmd = igp_pkg::IGP_OFF;
			end
			// every phase shares the one kill
			assign pif.kill = kill;
			// sequencer keeps dead time and minimum width
			igp_phase_seq #(
				.DEAD_CYC(DEAD_CYC),
				.MIN_CYC(MIN_CYC)
			) u_seq (
				.clk_in(core_clk_in),
				.rst_n_in(rst_n),
				.ph(pif)
			);
			assign up_drv[gi] = pif.up_drv;
			assign low_drv[gi] = pif.low_drv;
		end
	endgenerate
	// registered pin drivers, cleared on the edge after kill
	// the flop keeps decode glitches off the pins
	always_ff @(posedge core_clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			up_q_ff <= 3'h0;
			low_q_ff <= 3'h0;
		end
		else
		begin
			up_q_ff <= kill ? 3'h0 : up_drv;
			low_q_ff <= kill ? 3'h0 : low_drv;
		end
	end
	// phase u in bit 0, w in bit 2
	assign upper_gate_input_phase_u_out = up_q_ff[0];
	assign upper_gate_input_phase_v_out = up_q_ff[1];
	assign upper_gate_input_phase_w_out = up_q_ff[2];
	assign lower_gate_input_phase_u_out = low_q_ff[0];
	assign lower_gate_input_phase_v_out = low_q_ff[1];
	assign lower_gate_input_phase_w_out = low_q_ff[2];
	// shutdown released while enabled and no fault is seen
	// a fault pulls it low one flop after it is seen
	always_ff @(posedge core_clk_in or negedge rst_n)
	begin
		if (!rst_n)
			driver_shutdown_input_out <= 1'b0;
		else
			driver_shutdown_input_out <= enable_in && fault_n;
	end
	// status straight from the sync flop and the state
	assign fault_seen_out = !fault_n;
	assign ready_out = state_ff == ST_RUN;
endmodule // igp_gate_ctrl

/* igp_gate_monitor.sv */
`timescale 1ns/10ps
// Purpose: pin checks on the gate controller
// Assumes: bench counts, dead time 4 and pulse 3 cycles
// Notes: bound to every controller instance
module igp_gate_monitor (
	// clock and reset
	input wire logic core_clk_in,
	input wire logic reset_n_in,
	// user commands
	input wire logic enable_in,
	input wire logic [2:0] upper_req_in,
	input wire logic [2:0] lower_req_in,
	// fault pin of the module
	input wire logic fault_n_pin_in,
	// gate inputs to the module
	input wire logic upper_gate_input_phase_u_out,
	input wire logic upper_gate_input_phase_v_out,
	input wire logic upper_gate_input_phase_w_out,
	input wire logic lower_gate_input_phase_u_out,
	input wire logic lower_gate_input_phase_v_out,
	input wire logic lower_gate_input_phase_w_out,
	// shutdown pin and status
	input wire logic driver_shutdown_input_out,
	input wire logic fault_seen_out,
	input wire logic ready_out
);
	// gate pins gathered per side, phase u in bit 0
	wire [2:0] up = {upper_gate_input_phase_w_out,
		upper_gate_input_phase_v_out, upper_gate_input_phase_u_out};
	wire [2:0] lo = {lower_gate_input_phase_w_out,
		lower_gate_input_phase_v_out, lower_gate_input_phase_u_out};
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!reset_n_in);
	chk_no_cross: assert property (!(|(up & lo)))
		else $error("both gates of one phase high");
	chk_fault_kill: assert property ($fell(fault_n_pin_in) |-> ##[0:3]
		!(|{up, lo})) else $error("gates not dropped on fault pin");
	chk_seen_kill: assert property (fault_seen_out |=> !(|{up, lo}))
		else $error("gates high after fault seen");
	chk_seen_sync: assert property (!fault_n_pin_in [*3] |->
		fault_seen_out) else $error("fault pin not seen");
	chk_shutdown_off: assert property (
		fault_seen_out || !enable_in |=> !driver_shutdown_input_out)
		else $error("shutdown pin left high");
	chk_dead_off: assert property ($fell(up[0]) |-> !lo[0] [*3])
		else $error("lower on inside dead time");
	chk_dead_on: assert property ($fell(lo[0]) |-> !up[0] [*3])
		else $error("upper on inside dead time");
	chk_min_on: assert property ($rose(lo[0]) |-> lo[0] [*3])
		else $error("gate pulse too short");
	chk_ready_req: assert property ($rose(ready_out) |->
		$past(lower_req_in) != 3'h0) else $error("run without lower request");
	// main scenarios reached
	cover property ($rose(ready_out));
	cover property ($fell(fault_n_pin_in));
	cover property ($fell(up[0]) ##[1:30] $rose(lo[0]));
endmodule // igp_gate_monitor
bind igp_gate_ctrl igp_gate_monitor igp_gate_monitor_inst (.*);

/* igp_ipm_model.sv */
`timescale 1ns/10ps
// Purpose: behavioural power module on the far side
// Assumes: clear time counted in controller cycles
// Notes: fault pin is open drain, pull-up folded in
module igp_ipm_model #(
	parameter int CLR_CYC = 50
)(
	// controller clock, used to count the clear time
	input wire logic clk_in,
	// gate inputs from the controller
	input wire logic [2:0] up_in,
	input wire logic [2:0] lo_in,
	// shutdown pin, high lets the drivers run
	input wire logic shutdown_in,
	// protection causes
	input wire logic trip_in,
	input wire logic lsuv_in,
	input wire logic [2:0] hsuv_in,
	// open-drain fault pin, pull-up folded in
	output logic fault_n_out,
	// transistor gates
	output logic [2:0] gu_out,
	output logic [2:0] gl_out
);
	int clr_cnt = 0;
	logic run_ff = 1'h0;
	logic [2:0] hlock_ff = 3'h0;
	wire flt = trip_in | lsuv_in;
	// pull-up wins only once cause and clear time are over
	assign fault_n_out = (flt || clr_cnt > 0) ? 1'h0 : 1'h1;
	// no latch: restart needs clear time plus a lower input
	always @(posedge clk_in)
	begin
		if (flt)
		begin
			clr_cnt <= CLR_CYC;
			run_ff <= 1'h0;
		end
		else if (clr_cnt > 0)
			clr_cnt <= clr_cnt - 1;
		else if (|lo_in)
			run_ff <= 1'h1;
		hlock_ff <= hsuv_in | (hlock_ff & up_in);
	end
	// per phase: both inputs high drives neither gate
	assign gu_out = (run_ff & shutdown_in) ?
		up_in & ~lo_in & ~hlock_ff : 3'h0;
	assign gl_out = (run_ff & shutdown_in) ? lo_in & ~up_in : 3'h0;
endmodule // igp_ipm_model

/* igp_gate_ctrl_test.sv */
`timescale 1ns/10ps
// Purpose: self-checking bench for the gate controller
// Assumes: module model on the far side, short counts
// Notes: table rows first, fault and supply cases by hand
module igp_gate_ctrl_test;
	typedef struct packed {logic e; logic [2:0] u, l, xu, xl;} igp_row_t;
	// last two rows: a user stop, then a restart with upper held
	igp_row_t rows[8] = '{13'h1000, 13'h1200, 13'h11c7, 13'h1e38,
		13'h1aaa, 13'h16c0, 13'h08c0, 13'h18e3};
	logic clk = 1'h0, rst_n = 1'h0, en = 1'h0, trip = 1'h0, lsuv = 1'h0;
	logic [2:0] upr = 3'h0, lor = 3'h0, hsuv = 3'h0, gu, gl, mu, ml;
	logic shutdown, seen, rdy;
	wire flt_n;
	int n_fail = 0, cmp_count = 0, k;
	igp_gate_ctrl #(.CLEAR_CYC(50), .DEAD_CYC(4), .MIN_CYC(3))
	igp_gate_ctrl_inst (.core_clk_in(clk), .reset_n_in(rst_n),
		.enable_in(en), .upper_req_in(upr), .lower_req_in(lor),
		.fault_n_pin_in(flt_n), .upper_gate_input_phase_u_out(gu[0]),
		.upper_gate_input_phase_v_out(gu[1]),
		.upper_gate_input_phase_w_out(gu[2]),
		.lower_gate_input_phase_u_out(gl[0]),
		.lower_gate_input_phase_v_out(gl[1]),
		.lower_gate_input_phase_w_out(gl[2]),
		.driver_shutdown_input_out(shutdown), .fault_seen_out(seen),
		.ready_out(rdy));
	igp_ipm_model igp_ipm_model_inst (.clk_in(clk), .up_in(gu), .lo_in(gl),
		.hsuv_in(hsuv), .shutdown_in(shutdown), .trip_in(trip),
		.lsuv_in(lsuv), .fault_n_out(flt_n), .gu_out(mu), .gl_out(ml));
	initial forever #2 clk = ~clk;
	// inputs always move 1 ns after an edge
	task step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task chk(input string s, input logic [7:0] x, input logic [7:0] g);
		cmp_count++;
		if (g !== x)
		begin
			n_fail++;
			$display("MISMATCH %s exp %h got %h", s, x, g);
		end
	endtask
	task summarize;
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial
	begin
		step(6);
		rst_n = 1'h1;
		step(3);
		foreach (rows[i])
		begin
			{en, upr, lor} = {rows[i].e, rows[i].u, rows[i].l};
			step(20);
			chk("gates", 8'({rows[i].xu, rows[i].xl}), 8'({gu, gl}));
		end
		$display("table test done");
		// trip then low supply, lower request kept for restart
		for (int c = 0; c < 2; c++)
		begin
			{upr, lor} = 6'h07;
			step(20);
			{trip, lsuv} = c ? 2'h1 : 2'h2;
			step(4);
			chk("faulted", 8'h40, {shutdown, seen, gu, gl});
			step(10);
			{trip, lsuv} = 2'h0;
			k = 0;
			while (rdy !== 1'h1 && k < 500)
			begin
				step(1);
				k++;
			end
			if (k == 500)
			begin
				n_fail++;
				summarize();
			end
			chk("clear_wait", 8'h1, 8'(k >= 50));
			step(20);
			chk("restart", 8'h3f, 8'({gl, ml}));
		end
		$display("fault test done");
		{upr, lor} = 6'h38;
		step(20);
		hsuv = 3'h1;
		step(3);
		chk("upper_lock", 8'h6, 8'({seen, mu}));
		hsuv = 3'h0;
		step(5);
		chk("upper_hold", 8'h6, 8'(mu));
		upr = 3'h6;
		step(10);
		upr = 3'h7;
		step(20);
		chk("upper_free", 8'h7, 8'(mu));
		$display("supply test done");
		// mid-run reset: drives drop at once, upper refused until a run
		rst_n = 1'h0;
		step(1);
		chk("in_reset", 8'h00, {shutdown, rdy, gu, gl});
		rst_n = 1'h1;
		step(20);
		chk("upper_refused", 8'h80, {shutdown, rdy, gu, gl});
		{upr, lor} = 6'h07;
		step(20);
		chk("run_again", 8'hc7, {shutdown, rdy, gu, gl});
		$display("reset test done");
		summarize();
	end
endmodule // igp_gate_ctrl_test
